// [logic/artc_params.svh]
// constants for the adc result block transfer block
// assumes inclusion by the design file and by the bench package side
`ifndef ARTC_PARAMS_SVH
`define ARTC_PARAMS_SVH
// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define ARTC_OFS_RESULT   8'h00
`define ARTC_OFS_CTRL     8'h04
`define ARTC_OFS_COUNT    8'h08
`define ARTC_OFS_START    8'h0C
`define ARTC_OFS_FORMAT   8'h10
`define ARTC_OFS_STATUS   8'h14
`define ARTC_OFS_CLEAR    8'h18
`define ARTC_OFS_ENABLE   8'h1C
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define ARTC_CTRL_TB      3
`define ARTC_CTRL_CT      2
`define ARTC_CTRL_B1      1
`define ARTC_CTRL_FETCH   0
`define ARTC_CTRL_WMASK   8'h0D
`define ARTC_SA_MASK      16'hFFFE
`define ARTC_IRQ_BITS     2
`define ARTC_IRQ_BLOCK    0
`define ARTC_IRQ_DONE     1
// -----------------------------------------------------------------
// axi responses
// -----------------------------------------------------------------
`define ARTC_RESP_OKAY    2'h0
`define ARTC_RESP_SLVERR  2'h2
`endif

// [logic/artc_pkg.sv]
// types for the adc result block transfer block
// assumes the params header is included alongside
package artc_pkg;
   // transfer controller states
   typedef enum logic [1:0] {ARTC_IDLE, ARTC_WAIT, ARTC_WRITE} artc_state_t;
endpackage

// [logic/artc_top.sv]
// adc result formatter and block transfer controller with axi4-lite registers
// assumes results arrive as one-cycle strobes and memory accepts writes by handshake
//
// Contract
// RULE_01 - unsigned result right aligned, top zero
// RULE_02 - signed result left aligned, low zero
// RULE_03 - control bits seven to four read zero
// RULE_04 - single mode stops after one/two blocks
// RULE_05 - continuous runs until cleared or restarted; in ARTC_WRITE a clear acts as single mode and a restart is lost
// RULE_06 - block one flag shows last filled block
// RULE_07 - software keeps fetch control bit cleared
// RULE_08 - count sets transfers, zero disables controller
// RULE_09 - start address write initiates transfers
// RULE_10 - start address bit zero reads zero
// RULE_11 - done flag set per block, not result
// RULE_12 - format bit picks unsigned or signed
// RULE_13 - word at start plus twice index
// RULE_14 - continuous wraps to start after last block
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "artc_params.svh"
module artc_top
   import artc_pkg::*;
(
   input  wire logic        clk_in,          // 100 MHz module clock
   input  wire logic        rst_b_in,        // async active-low reset
   input  wire logic        s_awvalid_in,
   output logic             s_awready_out,
   input  wire logic [7:0]  s_awaddr_in,
   input  wire logic        s_wvalid_in,
   output logic             s_wready_out,
   input  wire logic [31:0] s_wdata_in,
   input  wire logic [3:0]  s_wstrb_in,
   output logic             s_bvalid_out,
   input  wire logic        s_bready_in,
   output logic [1:0]       s_bresp_out,
   input  wire logic        s_arvalid_in,
   output logic             s_arready_out,
   input  wire logic [7:0]  s_araddr_in,
   output logic             s_rvalid_out,
   input  wire logic        s_rready_in,
   output logic [31:0]      s_rdata_out,
   output logic [1:0]       s_rresp_out,
   input  wire logic        result_valid_in, // one-cycle pulse with a new result
   input  wire logic [9:0]  result_data_in,  // raw 10-bit conversion
   output logic             mem_valid_out,   // memory write request
   input  wire logic        mem_ready_in,    // memory accepts write
   output logic [15:0]      mem_addr_out,    // byte address of the word
   output logic [15:0]      mem_data_out,    // formatted result word
   output logic             irq_out          // level interrupt
);
   // -----------------------------------------------------------------
   // reset synchroniser
   // -----------------------------------------------------------------
   logic rst_meta; // first stage, read only by rst_sync
   logic rst_sync; // released reset used everywhere
   // release through two flops so deassertion is clean
   always_ff @(posedge clk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   // -----------------------------------------------------------------
   // state declarations
   // -----------------------------------------------------------------
   logic [15:0]  result_word, next_result_word;   // formatted result
   logic [3:0]   ctrl_bits, next_ctrl_bits;       // tb, ct, b1, fetch
   logic [7:0]   count, next_count;               // transfers per block
   logic [15:0]  start_addr, next_start_addr;     // word-aligned start
   logic         fmt_signed, next_fmt_signed;     // format select
   logic [1:0]   irq_status, next_irq_status;     // sticky events
   logic [1:0]   irq_enable, next_irq_enable;     // event enables
   logic         done_flag, next_done_flag;       // completion flag
   artc_state_t  state, next_state;               // controller state
   logic [7:0]   xfer_idx, next_xfer_idx;         // index in block
   logic         second_blk, next_second_blk;     // in block 2
   logic [15:0]  mem_addr, next_mem_addr;         // pending address
   logic [15:0]  mem_data, next_mem_data;         // pending data
   // axi slave state
   logic         aw_held, next_aw_held;
   logic         w_held, next_w_held;
   logic [7:0]   aw_addr, next_aw_addr;
   logic [31:0]  w_data, next_w_data;
   logic [3:0]   w_strb, next_w_strb;
   logic         bvalid, next_bvalid;
   logic [1:0]   bresp, next_bresp;
   logic         rvalid, next_rvalid;
   logic [31:0]  rdata, next_rdata;
   logic [1:0]   rresp, next_rresp;
   // -----------------------------------------------------------------
   // combinational decode
   // -----------------------------------------------------------------
   logic         wr_fire;  // both write halves present, response free
   logic         sa_write; // software wrote the start address
   logic         blk_end;  // a block's last write is accepted
   logic [15:0]  fmt_word; // incoming result in chosen layout
   logic [31:0]  rd_mux;   // read data selection
   logic         rd_ok;    // read address is mapped
   // writable control bits; block-one is hardware-owned, so software cannot fake it
   localparam logic [3:0] ctrl_wmask = 4'(`ARTC_CTRL_WMASK);
   assign s_awready_out = !aw_held;
   assign s_wready_out  = !w_held;
   assign s_arready_out = !rvalid;
   assign wr_fire  = aw_held && w_held && !bvalid;
   assign sa_write = wr_fire && (aw_addr == `ARTC_OFS_START) && (w_strb[1:0] != 2'h0);
   assign blk_end  = (state == ARTC_WRITE) && mem_ready_in && (xfer_idx == count - 8'h01);
   // format the incoming conversion
   always_comb
   begin
      // RULE_12 format select
      if (fmt_signed)
         // RULE_02 left aligned signed
         fmt_word = {result_data_in, 6'h00};
      else
         // RULE_01 right aligned unsigned
         fmt_word = {6'h00, result_data_in};
   end
   // read multiplexer, unmapped answers slverr
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_araddr_in)
         `ARTC_OFS_RESULT: rd_mux = {16'h0000, result_word};
         // RULE_03 reserved bits zero
         `ARTC_OFS_CTRL:   rd_mux = {28'h000_0000, ctrl_bits};
         `ARTC_OFS_COUNT:  rd_mux = {24'h00_0000, count};
         // RULE_10 bit zero reads zero
         `ARTC_OFS_START:  rd_mux = {16'h0000, start_addr & `ARTC_SA_MASK};
         `ARTC_OFS_FORMAT: rd_mux = {30'h0000_0000, done_flag, fmt_signed};
         `ARTC_OFS_STATUS: rd_mux = {30'h0000_0000, irq_status};
         `ARTC_OFS_ENABLE: rd_mux = {30'h0000_0000, irq_enable};
         `ARTC_OFS_CLEAR:  rd_mux = 32'h0000_0000;
         default:          rd_ok  = 1'b0;
      endcase
   end
   // -----------------------------------------------------------------
   // bus slave next state
   // -----------------------------------------------------------------
   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      // capture each write half in either order
      if (s_awvalid_in && !aw_held)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_awaddr_in;
      end
      if (s_wvalid_in && !w_held)
      begin
         next_w_held = 1'b1;
         next_w_data = s_wdata_in;
         next_w_strb = s_wstrb_in;
      end
      if (wr_fire)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (aw_addr[7:5] == 3'h0) ? `ARTC_RESP_OKAY : `ARTC_RESP_SLVERR;
      end
      else if (bvalid && s_bready_in)
         next_bvalid = 1'b0;
      // reads answer one cycle after the address
      if (s_arvalid_in && !rvalid)
      begin
         next_rvalid = 1'b1;
         next_rdata  = rd_mux;
         next_rresp  = rd_ok ? `ARTC_RESP_OKAY : `ARTC_RESP_SLVERR;
      end
      else if (rvalid && s_rready_in)
         next_rvalid = 1'b0;
   end
   // -----------------------------------------------------------------
   // registers and transfer controller next state
   // -----------------------------------------------------------------
   always_comb
   begin
      next_result_word = result_word;
      next_ctrl_bits   = ctrl_bits;
      next_count       = count;
      next_start_addr  = start_addr;
      next_fmt_signed  = fmt_signed;
      next_irq_status  = irq_status;
      next_irq_enable  = irq_enable;
      next_done_flag   = done_flag;
      next_state       = state;
      next_xfer_idx    = xfer_idx;
      next_second_blk  = second_blk;
      next_mem_addr    = mem_addr;
      next_mem_data    = mem_data;
      if (result_valid_in)
         next_result_word = fmt_word;
      // software writes, low byte lane; the start address takes either of the two low lanes
      if (wr_fire && w_strb[0])
      begin
         case (aw_addr)
            `ARTC_OFS_CTRL:
               // RULE_07 fetch bit stored only
               next_ctrl_bits = (ctrl_bits & ~ctrl_wmask)
                              | (w_data[3:0] & ctrl_wmask);
            `ARTC_OFS_COUNT:  next_count      = w_data[7:0];
            `ARTC_OFS_FORMAT:
            begin
               next_fmt_signed = w_data[0];
               next_done_flag  = w_data[1];
            end
            `ARTC_OFS_CLEAR:  next_irq_status = irq_status & ~w_data[1:0];
            `ARTC_OFS_ENABLE: next_irq_enable = w_data[1:0];
            default:          next_ctrl_bits  = next_ctrl_bits;
         endcase
      end
      if (sa_write)
         next_start_addr = {w_data[15:8], w_data[7:1], 1'b0};
      // controller sequence
      case (state)
         ARTC_IDLE:
         begin
            // RULE_09 start on address write
            if (sa_write)
            begin
               next_state      = ARTC_WAIT;
               next_xfer_idx   = 8'h00;
               next_second_blk = 1'b0;
            end
         end
         ARTC_WAIT:
         begin
            // RULE_08 zero count disables
            if (count == 8'h00)
               next_state = ARTC_IDLE;
            else if (result_valid_in)
            begin
               next_state    = ARTC_WRITE;
               next_mem_data = fmt_word;
               // RULE_13 start plus twice index
               next_mem_addr = start_addr
                  + {7'h00, second_blk ? count : 8'h00, 1'b0}
                  + {7'h00, xfer_idx, 1'b0};
            end
         end
         ARTC_WRITE:
         begin
            if (mem_ready_in)
            begin
               next_state    = ARTC_WAIT;
               next_xfer_idx = xfer_idx + 8'h01;
               if (blk_end)
               begin
                  next_xfer_idx = 8'h00;
                  // RULE_11 flag per block
                  next_done_flag = 1'b1;
                  // RULE_06 block one flag
                  next_ctrl_bits[`ARTC_CTRL_B1] = !second_blk;
                  if (ctrl_bits[`ARTC_CTRL_TB] && !second_blk)
                     next_second_blk = 1'b1;
                  else
                  begin
                     // RULE_14 wrap to start
                     next_second_blk = 1'b0;
                     // RULE_04 single mode stops
                     if (!ctrl_bits[`ARTC_CTRL_CT])
                        next_state = ARTC_IDLE;
                  end
               end
            end
         end
         default: next_state = ARTC_IDLE;
      endcase
      // RULE_05 continuous cleared stops
      if (ctrl_bits[`ARTC_CTRL_CT] && !next_ctrl_bits[`ARTC_CTRL_CT] && state != ARTC_WRITE)
         next_state = ARTC_IDLE;
      // RULE_05 restart on address write
      if (sa_write && state != ARTC_IDLE && state != ARTC_WRITE)
      begin
         next_state      = ARTC_WAIT;
         next_xfer_idx   = 8'h00;
         next_second_blk = 1'b0;
      end
      // sticky events, set wins over clear
      if (blk_end)
         next_irq_status[`ARTC_IRQ_BLOCK] = 1'b1;
      if (blk_end && !ctrl_bits[`ARTC_CTRL_CT] && (second_blk || !ctrl_bits[`ARTC_CTRL_TB]))
         next_irq_status[`ARTC_IRQ_DONE] = 1'b1;
   end
   // -----------------------------------------------------------------
   // registering
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_sync)
   begin
      if (!rst_sync)
      begin
         result_word <= 16'h0000;
         ctrl_bits   <= 4'h0;
         count       <= 8'h00;
         start_addr  <= 16'h0000;
         fmt_signed  <= 1'b0;
         irq_status  <= 2'h0;
         irq_enable  <= 2'h0;
         done_flag   <= 1'b0;
         state       <= ARTC_IDLE;
         xfer_idx    <= 8'h00;
         second_blk  <= 1'b0;
         mem_addr    <= 16'h0000;
         mem_data    <= 16'h0000;
         aw_held     <= 1'b0;
         w_held      <= 1'b0;
         aw_addr     <= 8'h00;
         w_data      <= 32'h0000_0000;
         w_strb      <= 4'h0;
         bvalid      <= 1'b0;
         bresp       <= 2'h0;
         rvalid      <= 1'b0;
         rdata       <= 32'h0000_0000;
         rresp       <= 2'h0;
      end
      else
      begin
         result_word <= next_result_word;
         ctrl_bits   <= next_ctrl_bits;
         count       <= next_count;
         start_addr  <= next_start_addr;
         fmt_signed  <= next_fmt_signed;
         irq_status  <= next_irq_status;
         irq_enable  <= next_irq_enable;
         done_flag   <= next_done_flag;
         state       <= next_state;
         xfer_idx    <= next_xfer_idx;
         second_blk  <= next_second_blk;
         mem_addr    <= next_mem_addr;
         mem_data    <= next_mem_data;
         aw_held     <= next_aw_held;
         w_held      <= next_w_held;
         aw_addr     <= next_aw_addr;
         w_data      <= next_w_data;
         w_strb      <= next_w_strb;
         bvalid      <= next_bvalid;
         bresp       <= next_bresp;
         rvalid      <= next_rvalid;
         rdata       <= next_rdata;
         rresp       <= next_rresp;
      end
   end
   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign s_bvalid_out  = bvalid;
   assign s_bresp_out   = bresp;
   assign s_rvalid_out  = rvalid;
   assign s_rdata_out   = rdata;
   assign s_rresp_out   = rresp;
   assign mem_valid_out = (state == ARTC_WRITE);
   assign mem_addr_out  = mem_addr;
   assign mem_data_out  = mem_data;
   assign irq_out       = |(irq_status & irq_enable);
endmodule

// [dv/artc_assertions.sv]
// checker for the result transfer block, bound to the top ports
// assumes one clock domain and the async active-low reset
`timescale 1ns/10ps
module artc_assertions
(
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        s_bvalid_out,
   input wire logic        s_bready_in,
   input wire logic        s_rvalid_out,
   input wire logic        s_rready_in,
   input wire logic [31:0] s_rdata_out,
   input wire logic [1:0]  s_rresp_out,
   input wire logic        result_valid_in,
   input wire logic        mem_valid_out,
   input wire logic        mem_ready_in,
   input wire logic [15:0] mem_addr_out,
   input wire logic [15:0] mem_data_out,
   input wire logic        irq_out
);
   // ---------------------------------------------
   // memory side
   // ---------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   mem_hold_a: assert property (
      mem_valid_out && !mem_ready_in |=> mem_valid_out && $stable(mem_addr_out)
      && $stable(mem_data_out)) else $error("memory request changed before taken");
   mem_drop_a: assert property (
      $fell(mem_valid_out) |-> $past(mem_ready_in)) else $error("request dropped untaken");
   mem_cause_a: assert property (
      $rose(mem_valid_out) |-> $past(result_valid_in)) else $error("write without result");
   word_align_a: assert property (
      mem_valid_out |-> !mem_addr_out[0]) else $error("odd memory address");
   fmt_zero_a: assert property (
      mem_valid_out |-> mem_data_out[15:10] == 6'h00 || mem_data_out[5:0] == 6'h00)
      else $error("formatted word lacks zero field");
   // ---------------------------------------------
   // register bus
   // ---------------------------------------------
   write_resp_a: assert property (
      s_bvalid_out && !s_bready_in |=> s_bvalid_out) else $error("write answer withdrawn");
   read_hold_a: assert property (
      s_rvalid_out && !s_rready_in |=> s_rvalid_out && $stable(s_rdata_out))
      else $error("read answer changed");
   read_width_a: assert property (
      s_rvalid_out |-> s_rdata_out[31:16] == 16'h0000) else $error("upper read bits set");
   // main scenarios
   mem_write_c: cover property (mem_valid_out && mem_ready_in);
   irq_rise_c: cover property ($rose(irq_out));
   slverr_c: cover property (s_rvalid_out && s_rresp_out == 2'h2);
endmodule
bind artc_top artc_assertions u_artc_assertions (.clk_in, .rst_b_in, .s_bvalid_out,
   .s_bready_in, .s_rvalid_out, .s_rready_in, .s_rdata_out, .s_rresp_out,
   .result_valid_in, .mem_valid_out, .mem_ready_in, .mem_addr_out, .mem_data_out, .irq_out);

// [dv/artc_mem_model.sv]
// memory partner: takes result words by valid/ready handshake
// assumes the bench reads nwr, last_addr and last_data directly
`timescale 1ns/10ps
module artc_mem_model
(
   input  wire logic        clk_in,
   input  wire logic        valid_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in,
   input  wire logic        slow_in,   // random stalls when high
   output logic             ready_out
);
   int          nwr = 0;              // writes taken
   logic [15:0] last_addr = 16'h0000;
   logic [15:0] last_data = 16'h0000;
   // a word lands only at the handshake edge; ready may drop at any time
   always @(posedge clk_in)
   begin
      if (valid_in && ready_out)
      begin
         nwr <= nwr + 1;
         last_addr <= addr_in;
         last_data <= data_in;
      end
      ready_out <= slow_in ? ($urandom % 3 == 0) : 1'b1;
   end
endmodule

// [dv/adc_result_block_transfer_tb.sv]
// self-checking bench for the result transfer block
// assumes the memory model as partner and one 100 MHz clock
`timescale 1ns/10ps
`include "artc_params.svh"
module adc_result_block_transfer_tb;
   logic clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, rv = 0, slow = 0;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0;
   logic [3:0]  wst = 4'hF;
   logic [9:0]  rd = 0;
   wire         awr, wrd, bv, arr, rvl, mv, mrdy, irq;
   wire [1:0]   br, rr;
   wire [31:0]  rdt;
   wire [15:0]  ma, mdt;
   int          mismatches = 0, num_checks = 0, cyc = 0, n, m, i, tot;
   logic [15:0] sa;
   bit          sg;
   always #5 clk = ~clk;
   artc_top u_artc_top (.clk_in(clk), .rst_b_in(rst_b), .s_awvalid_in(awv), .s_awready_out(awr),
      .s_awaddr_in(awa), .s_wvalid_in(wv), .s_wready_out(wrd), .s_wdata_in(wd), .s_wstrb_in(wst),
      .s_bvalid_out(bv), .s_bready_in(bre), .s_bresp_out(br), .s_arvalid_in(arv),
      .s_arready_out(arr), .s_araddr_in(ara), .s_rvalid_out(rvl), .s_rready_in(rre),
      .s_rdata_out(rdt), .s_rresp_out(rr), .result_valid_in(rv), .result_data_in(rd),
      .mem_valid_out(mv), .mem_ready_in(mrdy), .mem_addr_out(ma), .mem_data_out(mdt),
      .irq_out(irq));
   artc_mem_model u_artc_mem_model (.clk_in(clk), .valid_in(mv), .addr_in(ma), .data_in(mdt),
      .slow_in(slow), .ready_out(mrdy));
   task end_of_test;
   begin
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   end
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
   begin
      num_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   end
   endtask
   // expected word for a raw result in the chosen layout
   function logic [15:0] fw(input logic [9:0] r, input bit s);
      return s ? {r, 6'h00} : {6'h00, r};
   endfunction
   // handshakes are judged at the rising edge that samples them, released right after;
   // automatic so the done flags start clear on every call; one idle edge closes each call
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      bit tb;
      logic [1:0] rs;
   begin
      awv <= 1; awa <= a; wv <= 1; wd <= d; bre <= 1;
      for (k = 0; k < 50 && !tb; k++)
      begin
         @(posedge clk);
         if (awv && awr)
            awv <= 0;
         if (wv && wrd)
            wv <= 0;
         tb = bv;
         rs = br;
         if (tb)
            bre <= 0;
      end
      @(posedge clk);
      chk("bresp", {tb, rs}, {1'b1, er});
   end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int k;
      bit tr;
      logic [31:0] d;
      logic [1:0] rs;
   begin
      arv <= 1; ara <= a; rre <= 1;
      for (k = 0; k < 50 && !tr; k++)
      begin
         @(posedge clk);
         if (arv && arr)
            arv <= 0;
         tr = rvl;
         d  = rdt;
         rs = rr;
         if (tr)
            rre <= 0;
      end
      @(posedge clk);
      chk("rdata", d, e);
      chk("rresp", {tr, rs}, {1'b1, er});
   end
   endtask
   // one result pulse; a write is expected at ea or none at all
   task send(input bit we, input logic [15:0] ea);
      int k0, k;
      logic [9:0] r;
   begin
      r = 10'($urandom);
      k0 = u_artc_mem_model.nwr; rv <= 1; rd <= r;
      @(posedge clk);
      rv <= 0;
      for (k = 0; k < 40 && u_artc_mem_model.nwr == k0; k++) @(posedge clk);
      chk("writes", u_artc_mem_model.nwr - k0, we);
      if (we) chk("addr", u_artc_mem_model.last_addr, ea);
      if (we) chk("data", u_artc_mem_model.last_data, fw(r, sg));
      // the readable result register follows every conversion, transfer or not
      rdc(`ARTC_OFS_RESULT, {16'h0000, fw(r, sg)}, `ARTC_RESP_OKAY);
      repeat (2) @(posedge clk);
   end
   endtask
   // hang guard well above the expected run length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         mismatches++;
         end_of_test;
      end
   end
   initial
   begin
      void'($urandom(9003));
      repeat (4) @(posedge clk);
      rst_b <= 1;
      repeat (3) @(posedge clk);
      rdc(`ARTC_OFS_CTRL, 0, `ARTC_RESP_OKAY);
      wr(`ARTC_OFS_CTRL, 32'hF5, `ARTC_RESP_OKAY);
      rdc(`ARTC_OFS_CTRL, 32'h05, `ARTC_RESP_OKAY);
      wr(`ARTC_OFS_CTRL, 0, `ARTC_RESP_OKAY);
      wr(`ARTC_OFS_START, 32'hFFFF, `ARTC_RESP_OKAY);
      rdc(`ARTC_OFS_START, 32'hFFFE, `ARTC_RESP_OKAY);
      send(0, 0);
      wr(8'h20, 0, `ARTC_RESP_SLVERR);
      rdc(8'h20, 0, `ARTC_RESP_SLVERR);
      wr(`ARTC_OFS_ENABLE, 3, `ARTC_RESP_OKAY);
      // modes: one block, two blocks, continuous one block
      for (m = 0; m < 3; m++)
      begin
         n = 2 + $urandom % 3; sg = $urandom % 2; slow <= $urandom % 2;
         sa = 16'h1000 + 16'($urandom % 256) * 2;
         tot = (m == 2) ? 2 * n + 1 : n * (m + 1) + 1;
         wr(`ARTC_OFS_FORMAT, sg, `ARTC_RESP_OKAY);
         wr(`ARTC_OFS_COUNT, n, `ARTC_RESP_OKAY);
         wr(`ARTC_OFS_CTRL, (m == 1) ? 8 : 4 * (m / 2), `ARTC_RESP_OKAY);
         wr(`ARTC_OFS_CLEAR, 3, `ARTC_RESP_OKAY);
         wr(`ARTC_OFS_START, sa, `ARTC_RESP_OKAY);
         for (i = 0; i < tot; i++)
         begin
            if (i == 1) rdc(`ARTC_OFS_FORMAT, sg, `ARTC_RESP_OKAY);
            // block one just filled; mode 2 enters with the flag left low by mode 1
            if (m > 0 && i == n) rdc(`ARTC_OFS_CTRL, (m == 1) ? 32'h0A : 32'h06, `ARTC_RESP_OKAY);
            // continuous wraps back to the start address after its one block
            send(m == 2 || i < n * (m + 1), sa + 16'(2 * (i % (n * (m % 2 + 1)))));
         end
         if (m < 2)
         begin
            rdc(`ARTC_OFS_STATUS, 3, `ARTC_RESP_OKAY);
            rdc(`ARTC_OFS_FORMAT, 2 | sg, `ARTC_RESP_OKAY);
         end
         if (m == 1) rdc(`ARTC_OFS_CTRL, 8, `ARTC_RESP_OKAY);
         chk("irq", irq, 1);
         wr(`ARTC_OFS_ENABLE, 0, `ARTC_RESP_OKAY);
         chk("irq masked", irq, 0);
         wr(`ARTC_OFS_ENABLE, 3, `ARTC_RESP_OKAY);
         if (m == 2)
         begin
            rdc(`ARTC_OFS_STATUS, 1, `ARTC_RESP_OKAY);
            // a start write mid-run restarts at index zero, not at the next slot
            wr(`ARTC_OFS_START, sa, `ARTC_RESP_OKAY);
            send(1, sa);
            wr(`ARTC_OFS_CTRL, 0, `ARTC_RESP_OKAY);
            repeat (4) @(posedge clk);
            send(0, 0);
         end
         wr(`ARTC_OFS_CLEAR, 3, `ARTC_RESP_OKAY);
         chk("irq cleared", irq, 0);
      end
      end_of_test;
   end
endmodule
